// File: common/dswk_defines.vh
// Constants for the deep sleep wake source capture block
`ifndef DSWK_DEFINES_VH
`define DSWK_DEFINES_VH

// Register byte offsets
`define DSWK_OFF_WAKE 12'h000
`define DSWK_OFF_CTRL 12'h004
`define DSWK_OFF_IRQ_STAT 12'h008
`define DSWK_OFF_IRQ_MASK 12'h00C

// Wake source flag positions
`define DSWK_BIT_IOC 8
`define DSWK_BIT_FAULT 7
`define DSWK_BIT_WDT 4
`define DSWK_BIT_RTC 3
`define DSWK_BIT_MASTER_CLEAR_PIN 2
`define DSWK_WAKE_MASK 32'h0000019C
`define DSWK_WAKE_RESET 32'h00000000

// Control register fields
`define DSWK_BIT_ENTRY 15
`define DSWK_BIT_MASTER_CLEAR_PIN_EN 1
`define DSWK_BIT_RELEASE 0
`define DSWK_MASTER_CLEAR_PIN_EN_RESET 1'b1

// Interrupt status and mask fields
`define DSWK_IRQ_WIDTH 3
`define DSWK_IRQ_WAKE 0
`define DSWK_IRQ_MISMATCH 1
`define DSWK_IRQ_BLOCKED 2
`define DSWK_IRQ_RESET 3'h0

// Synchroniser depth
`define DSWK_SYNC_STAGES 2

`endif

// File: src/dswk_sync.v
// Two-stage synchroniser for a group of level inputs
`timescale 1ns/1ps
`include "dswk_defines.vh"

module dswk_sync #(
   parameter WIDTH = 5
) (
   ref_clk,
   rst_n,
   asyncIn,
   syncOut
);
   input wire ref_clk;
   input wire rst_n;
   input wire [WIDTH-1:0] asyncIn;
   output reg [WIDTH-1:0] syncOut;

   // First stage feeds only the second stage
   reg [WIDTH-1:0] metaStage;

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         metaStage <= {WIDTH{1'b0}};
         syncOut <= {WIDTH{1'b0}};
      end else begin
         metaStage <= asyncIn;
         syncOut <= metaStage;
      end
   end
endmodule

// File: src/dswk_wake_capture.v
// Deep sleep wake source capture with APB register access
`timescale 1ns/1ps
`include "dswk_defines.vh"

module dswk_wake_capture #(
   parameter ADDR_WIDTH = 12
) (
   ref_clk,
   rst_n,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   iocEvent,
   sleepFault,
   sleepWatchdogTimeout,
   calendarAlarm,
   master_clear_pin_n,
   irq,
   deepSleepActive
);
   input wire ref_clk;
   input wire rst_n;
   input wire psel;
   input wire penable;
   input wire pwrite;
   input wire [ADDR_WIDTH-1:0] paddr;
   input wire [31:0] pwdata;
   output reg [31:0] prdata;
   output reg pready;
   output reg pslverr;
   input wire iocEvent;
   input wire sleepFault;
   input wire sleepWatchdogTimeout;
   input wire calendarAlarm;
   input wire master_clear_pin_n;
   output reg irq;
   output reg deepSleepActive;

   ////////////////////////////////////////////////////////////////////////
   // Address decode helper

   function addrHit;
      input [ADDR_WIDTH-1:0] addr;
      input [11:0] offset;
      begin
         addrHit = (addr == offset[ADDR_WIDTH-1:0]);
      end
   endfunction

   // One flag placed at its bit position in a word
   function [31:0] bitAt;
      input flag;
      input integer pos;
      begin
         bitAt = {31'h0, flag} << pos;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Source synchronisation

   // Change, fault, watchdog, alarm, master clear
   localparam NUM_SOURCES = 5;

   wire [NUM_SOURCES-1:0] rawSources;
   wire [NUM_SOURCES-1:0] syncSources;

   // Raw pins feed only the first flop; polarity is fixed after the second
   assign rawSources = {iocEvent, sleepFault, sleepWatchdogTimeout, calendarAlarm, master_clear_pin_n};

   dswk_sync #(
      .WIDTH(NUM_SOURCES)
   ) sourceSync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .asyncIn(rawSources),
      .syncOut(syncSources)
   );

   wire iocSync;
   wire faultSync;
   wire wdtSync;
   wire rtcSync;
   wire mclrAssertedSync;

   assign iocSync = syncSources[4];
   assign faultSync = syncSources[3];
   assign wdtSync = syncSources[2];
   assign rtcSync = syncSources[1];
   // Pin is active low; the flops reset to zero, so this reads asserted for
   // two edges after reset, harmless because the block is awake then
   assign mclrAssertedSync = ~syncSources[0];

   ////////////////////////////////////////////////////////////////////////
   // State

   reg [31:0] wakeFlags;
   reg releaseHold;
   reg mclrEnable;
   reg [`DSWK_IRQ_WIDTH-1:0] irqStatus;
   reg [`DSWK_IRQ_WIDTH-1:0] irqMask;
   reg writeArmed;
   reg [31:0] armedValue;

   reg [31:0] next_wakeFlags;
   reg next_releaseHold;
   reg next_mclrEnable;
   reg next_deepSleepActive;
   reg [`DSWK_IRQ_WIDTH-1:0] next_irqStatus;
   reg [`DSWK_IRQ_WIDTH-1:0] next_irqMask;
   reg next_writeArmed;
   reg [31:0] next_armedValue;
   reg [31:0] next_prdata;
   reg next_pready;
   reg next_pslverr;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode

   wire hitWake;
   wire hitCtrl;
   wire hitIrqStat;
   wire hitIrqMask;
   wire mapped;
   wire accessDone;
   wire writeDone;
   wire ctrlWrite;
   wire releaseClear;

   assign hitWake = addrHit(paddr, `DSWK_OFF_WAKE);
   assign hitCtrl = addrHit(paddr, `DSWK_OFF_CTRL);
   assign hitIrqStat = addrHit(paddr, `DSWK_OFF_IRQ_STAT);
   assign hitIrqMask = addrHit(paddr, `DSWK_OFF_IRQ_MASK);
   // Anything else, misaligned offsets included, answers with an error
   assign mapped = hitWake | hitCtrl | hitIrqStat | hitIrqMask;

   // Effects land only at the edge where the master sees pready high
   assign accessDone = psel & penable & pready;
   assign writeDone = accessDone & pwrite & mapped;
   assign ctrlWrite = writeDone & hitCtrl;
   // A one in the release field keeps the hold; only a zero lets flag writes back in
   assign releaseClear = ctrlWrite & ~pwdata[`DSWK_BIT_RELEASE];

   ////////////////////////////////////////////////////////////////////////
   // Wake source capture

   wire [31:0] hwSet;
   wire anyWake;
   wire entryRequest;

   assign hwSet = bitAt(iocSync, `DSWK_BIT_IOC) |
                  bitAt(faultSync, `DSWK_BIT_FAULT) |
                  bitAt(wdtSync, `DSWK_BIT_WDT) |
                  bitAt(rtcSync, `DSWK_BIT_RTC) |
                  bitAt(mclrEnable & mclrAssertedSync, `DSWK_BIT_MASTER_CLEAR_PIN);

   // Sources only count while the device is asleep
   assign anyWake = deepSleepActive & (|hwSet);

   // Re-entering sleep while already asleep is a no-op
   assign entryRequest = ctrlWrite & pwdata[`DSWK_BIT_ENTRY] & ~deepSleepActive;

   ////////////////////////////////////////////////////////////////////////
   // Doubled-write discipline on the flag register

   wire wakeWrite;
   wire wakeBlocked;
   wire wakeCommit;
   wire wakeMismatch;

   assign wakeWrite = writeDone & hitWake;
   assign wakeBlocked = wakeWrite & releaseHold;
   // A commit needs an armed first write as the previous access, same data
   assign wakeCommit = wakeWrite & ~releaseHold & writeArmed & (pwdata == armedValue);
   assign wakeMismatch = wakeWrite & ~releaseHold & writeArmed & (pwdata != armedValue);

   always @* begin
      next_writeArmed = writeArmed;
      next_armedValue = armedValue;
      if (accessDone) begin
         if (wakeWrite & ~releaseHold & ~wakeCommit) begin
            // First half, or a mismatch that restarts the pair
            next_writeArmed = 1'b1;
            next_armedValue = pwdata;
         end else begin
            // Any other access between the two writes breaks the pair
            next_writeArmed = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Flags and sleep state

   always @* begin
      next_wakeFlags = wakeFlags;
      next_deepSleepActive = deepSleepActive;
      next_releaseHold = releaseHold;
      next_mclrEnable = mclrEnable;
      if (wakeCommit) begin
         next_wakeFlags = pwdata & `DSWK_WAKE_MASK;
      end
      if (entryRequest) begin
         next_wakeFlags = `DSWK_WAKE_RESET;
         next_deepSleepActive = 1'b1;
      end
      // Hardware set wins over a software write in the same cycle
      if (deepSleepActive) begin
         next_wakeFlags = next_wakeFlags | (hwSet & `DSWK_WAKE_MASK);
      end
      if (ctrlWrite) begin
         next_mclrEnable = pwdata[`DSWK_BIT_MASTER_CLEAR_PIN_EN];
      end
      if (releaseClear) begin
         next_releaseHold = 1'b0;
      end
      // Wake sets release last, so a same-cycle clear loses
      if (anyWake) begin
         next_deepSleepActive = 1'b0;
         next_releaseHold = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status and mask

   wire [`DSWK_IRQ_WIDTH-1:0] irqEvents;
   wire [31:0] irqEventWord;

   assign irqEventWord = bitAt(anyWake, `DSWK_IRQ_WAKE) |
                         bitAt(wakeMismatch, `DSWK_IRQ_MISMATCH) |
                         bitAt(wakeBlocked, `DSWK_IRQ_BLOCKED);
   // Event bits sit at the bottom of the word; the upper bits are always zero
   assign irqEvents = irqEventWord[`DSWK_IRQ_WIDTH-1:0];

   always @* begin
      next_irqStatus = irqStatus;
      next_irqMask = irqMask;
      if (writeDone & hitIrqStat) begin
         next_irqStatus = irqStatus & ~pwdata[`DSWK_IRQ_WIDTH-1:0];
      end
      if (writeDone & hitIrqMask) begin
         next_irqMask = pwdata[`DSWK_IRQ_WIDTH-1:0];
      end
      // Set wins over write-one-to-clear
      next_irqStatus = next_irqStatus | irqEvents;
   end

   ////////////////////////////////////////////////////////////////////////
   // APB answer: one wait state, data and error registered with pready
   // Read data is captured a cycle before completion; a flag set in that cycle shows on the next read

   always @* begin
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      if (psel & penable & ~pready) begin
         next_pready = 1'b1;
         next_pslverr = ~mapped;
         if (!pwrite) begin
            if (hitWake) begin
               next_prdata = wakeFlags & `DSWK_WAKE_MASK;
            end else if (hitCtrl) begin
               next_prdata[`DSWK_BIT_ENTRY] = deepSleepActive;
               next_prdata[`DSWK_BIT_MASTER_CLEAR_PIN_EN] = mclrEnable;
               next_prdata[`DSWK_BIT_RELEASE] = releaseHold;
            end else if (hitIrqStat) begin
               next_prdata[`DSWK_IRQ_WIDTH-1:0] = irqStatus;
            end else if (hitIrqMask) begin
               next_prdata[`DSWK_IRQ_WIDTH-1:0] = irqMask;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sleep state and flag registers

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wakeFlags <= `DSWK_WAKE_RESET;
         deepSleepActive <= 1'b0;
         releaseHold <= 1'b0;
         mclrEnable <= `DSWK_MASTER_CLEAR_PIN_EN_RESET;
      end else begin
         wakeFlags <= next_wakeFlags;
         deepSleepActive <= next_deepSleepActive;
         releaseHold <= next_releaseHold;
         mclrEnable <= next_mclrEnable;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write pair tracking

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         writeArmed <= 1'b0;
         armedValue <= 32'h0000_0000;
      end else begin
         writeArmed <= next_writeArmed;
         armedValue <= next_armedValue;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt registers

   // Built from next state so irq rises on the same edge as its status bit
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irqStatus <= `DSWK_IRQ_RESET;
         irqMask <= `DSWK_IRQ_RESET;
         irq <= 1'b0;
      end else begin
         irqStatus <= next_irqStatus;
         irqMask <= next_irqMask;
         irq <= |(next_irqStatus & next_irqMask);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus answer registers

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end
endmodule

// File: tb/dswk_wake_capture_asserts.sv
// Port assertions for the wake capture block
`timescale 1ns/1ps
module dswk_wake_capture_asserts #(
   parameter ADDR_WIDTH = 12
) (
   input wire ref_clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_WIDTH-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire iocEvent,
   input wire sleepFault,
   input wire sleepWatchdogTimeout,
   input wire calendarAlarm,
   input wire master_clear_pin_n,
   input wire irq,
   input wire deepSleepActive
);
   wire xfer;
   assign xfer = psel && penable && pready;
   // Master clear wakes only while its enable field, as last written, is set
   logic mclrEnSeen;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mclrEnSeen <= 1'b1;
      end else if (xfer && pwrite && paddr == 12'h004) begin
         mclrEnSeen <= pwdata[1];
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////
   // Sync adds two edges, capture one more
   a_ioc_wake: assert property (deepSleepActive && iocEvent |-> ##[1:4] !deepSleepActive)
      else $error("No wake on change");
   a_fault_wake: assert property (deepSleepActive && sleepFault |-> ##[1:4] !deepSleepActive)
      else $error("No wake on fault");
   a_wdt_wake: assert property (deepSleepActive && sleepWatchdogTimeout [*2] |-> ##[0:3] !deepSleepActive)
      else $error("No wake on watchdog");
   a_alarm_wake: assert property (deepSleepActive && $rose(calendarAlarm) |-> ##[1:4] $fell(deepSleepActive))
      else $error("No wake on alarm");
   a_master_clear_pin_wake: assert property (deepSleepActive && mclrEnSeen && !master_clear_pin_n |-> ##[1:4] !deepSleepActive)
      else $error("No wake on master clear");
   a_entry_sleeps: assert property (xfer && pwrite && paddr == 12'h004 && pwdata[15] && !deepSleepActive
      |=> ##[0:1] deepSleepActive) else $error("Entry ignored");
   a_flag_unimpl: assert property (xfer && !pwrite && paddr == 12'h000 |-> (prdata & 32'hFFFFFE63) == 32'h0)
      else $error("Unimplemented flag bit set");
   a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("Wait state count wrong");
   a_unmapped_err: assert property (xfer && paddr > 12'h00C |-> pslverr && prdata == 32'h0)
      else $error("Unmapped access accepted");
endmodule

bind dswk_wake_capture dswk_wake_capture_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) i_dswk_wake_capture_asserts (
   .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .iocEvent,
   .sleepFault, .sleepWatchdogTimeout, .calendarAlarm, .master_clear_pin_n, .irq, .deepSleepActive);

// File: tb/tb.sv
// Self-checking bench for the wake capture block
`timescale 1ns/1ps
module tb;
   logic ref_clk;
   logic rst_n;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [4:0] src;
   logic irq;
   logic deepSleepActive;
   logic [31:0] rdv;
   logic errv;
   int fail_count;
   int compares;
   int wakeBit [5] = '{8, 7, 4, 3, 2};

   dswk_wake_capture i_dswk_wake_capture (
      .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .iocEvent(src[0]), .sleepFault(src[1]), .sleepWatchdogTimeout(src[2]), .calendarAlarm(src[3]),
      .master_clear_pin_n(~src[4]), .irq(irq), .deepSleepActive(deepSleepActive));

   ////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask

   // Entered just after a rising edge; holds request until pready seen
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // No wait limit here; the watchdog ends a hung transfer
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdv, exp);
   endtask

   task pulse(input logic [4:0] s);
      src <= s;
      repeat (6) @(posedge ref_clk);
      src <= 5'h00;
      // Let the synchroniser drain before the next access
      repeat (4) @(posedge ref_clk);
   endtask

   task wake(input int i, input logic expIrq);
      wr(12'h004, 32'h00008002);
      chk({31'h0, deepSleepActive}, 32'h1);
      rd(12'h000, 32'h0);
      pulse(5'h01 << i);
      chk({31'h0, deepSleepActive}, 32'h0);
      rd(12'h004, 32'h3);
      chk({31'h0, irq}, {31'h0, expIrq});
      rd(12'h008, 32'h1);
      wr(12'h008, 32'h1);
      chk({31'h0, irq}, 32'h0);
   endtask

   task final_report;
      $display("Comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   initial begin
      repeat (8000) @(posedge ref_clk);
      fail_count++;
      final_report;
   end

   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      src = 5'h00;
      fail_count = 0;
      compares = 0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rd(12'h000, 32'h0);
      rd(12'h004, 32'h2);
      rd(12'h00C, 32'h0);
      wr(12'h00C, 32'h7);
      // Sources while awake must not be captured
      pulse(5'h1F);
      rd(12'h000, 32'h0);
      for (int i = 0; i < 5; i++) begin
         wake(i, 1'b1);
         rd(12'h000, 32'h1 << wakeBit[i]);
      end
      wr(12'h000, 32'h0);
      wr(12'h000, 32'h0);
      rd(12'h000, 32'h4);
      rd(12'h008, 32'h4);
      wr(12'h004, 32'h2);
      rd(12'h004, 32'h2);
      wr(12'h000, 32'h0);
      rd(12'h000, 32'h4);
      wr(12'h000, 32'hFFFFFFFF);
      wr(12'h000, 32'hFFFFFFFF);
      rd(12'h000, 32'h19C);
      wr(12'h000, 32'h4);
      wr(12'h000, 32'h8);
      rd(12'h008, 32'h6);
      chk({31'h0, irq}, 32'h1);
      wr(12'h008, 32'h6);
      wr(12'h00C, 32'h0);
      wake(0, 1'b0);
      // Master clear disabled: the pin must not wake, an alarm still does
      wr(12'h004, 32'h00008000);
      pulse(5'h10);
      chk({31'h0, deepSleepActive}, 32'h1);
      pulse(5'h08);
      rd(12'h004, 32'h1);
      rd(12'h000, 32'h8);
      apb(1'b0, 12'h010, 32'h0);
      chk(rdv, 32'h0);
      chk({31'h0, errv}, 32'h1);
      final_report;
   end
endmodule
